/* scpec_pkg.sv */
// package for the serial configuration power-on and error controller
// assumes a 40 MHz system clock and a slow link clock sampled by it
package scpec_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned POR_MS = 200;
   localparam int unsigned POR_CYCLES = (POR_MS * (CLK_HZ / 1000));
   localparam int unsigned DONE_WAIT_CLKS = 16;
   localparam int unsigned CLK_DIV = 4;
   localparam int unsigned ERR_HOLD = 1;
   localparam logic IDLE_DATA_HIGH = 1'b1;

   typedef enum logic [2:0] {
      SCPEC_POR, SCPEC_DECIDE, SCPEC_SEND, SCPEC_WAIT_DONE,
      SCPEC_IDLE, SCPEC_SLAVE, SCPEC_ERROR, SCPEC_RECOVER
   } scpec_state_t;

   typedef struct packed {
      logic status_low;
      logic sel_high;
   } scpec_pins_t;
endpackage

/* scpec_sync.sv */
// two-flop synchroniser for one bus of pin inputs
// assumes inputs are asynchronous to i_clk_sys
module scpec_sync
   import scpec_pkg::*;
#(
   parameter int unsigned WIDTH = 2
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         meta_q <= '1;
         o_sync <= '1;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule

/* scpec_ctrl.sv */
// power-on delay, master/slave choice, error detection and restart for a
// serial configuration memory; assumes status line and chip select pulled up
// Overview of operation
// [R1] after reset the block waits a power-on delay of at most 200 ms before sending data.
// [R2] throughout that delay the status line is driven low.
// [R3] when the delay ends the status line is released to its pull-up.
// [R4] chip select high at release puts the block in slave mode, output off, clock an input.
// [R5] the target must hold its done line low before the delay ends so the block stays master.
// [R6] chip select going high before all data is sent makes the master pull the status line low.
// [R7] after the last bit the master waits 16 clock cycles for chip select high, else errors.
// [R8] after an error the block restarts by itself only when auto-restart is enabled.
// [R9] a low on the status line driven by the target is taken as a reset.
// [R10] while the status line is low the address counter clears and data is tri-stated.
// [R11] after the status line rises, counter and output run only while chip select is low.
// [R12] after all data and chip select high the master idles with clock low, data high or off.
// [R13] the master keeps the configuration clock running for slaves until configuration ends; the block stops it at most 16 clock cycles after its last bit.
// [R14] as master one bit is output per clock cycle and the counter advances each cycle.
// [R15] an error holds the status line low at least one cycle, then waits for it to go high.
module scpec_ctrl
   import scpec_pkg::*;
#(
   parameter int unsigned POR_COUNT = POR_CYCLES,
   parameter int unsigned ADDR_W = 16,
   parameter logic [ADDR_W-1:0] LAST_ADDR = 16'hFFFF
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_status_line,
   input wire logic i_chip_select_n,
   input wire logic i_config_clock,
   input wire logic i_auto_restart,
   input wire logic i_mem_bit,
   output logic o_status_line_oe_n,
   output logic o_status_line,
   output logic o_config_clock,
   output logic o_config_clock_oe_n,
   output logic o_data,
   output logic o_data_oe_n,
   output logic o_cascade_select_out_n,
   output logic [ADDR_W-1:0] o_mem_addr,
   output logic o_slave_mode,
   output logic o_error
);
   localparam logic [1:0] DIV_LAST = 2'(CLK_DIV - 1);
   localparam logic [1:0] DIV_HALF = 2'(CLK_DIV / 2 - 1);
   localparam logic [4:0] DONE_LAST = 5'(DONE_WAIT_CLKS);

   logic [1:0] pins_s;
   scpec_pins_t pins;
   logic link_clk_s;
   logic link_clk_q;
   scpec_state_t state_q;
   logic [31:0] por_cnt_q;
   logic [1:0] div_q;
   logic [4:0] done_cnt_q;
   logic [ADDR_W-1:0] addr_q;
   logic hold_q;
   logic clk_fall;
   logic slave_rise;

   scpec_sync #(.WIDTH(3)) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_async({i_status_line, i_chip_select_n, i_config_clock}),
      .o_sync({pins_s, link_clk_s})
   );
   assign pins.status_low = ~pins_s[1];
   assign pins.sel_high = pins_s[0];

   // internal oscillator divider; in slave mode the external clock is used
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         div_q <= 2'h0;
      end else if (state_q == SCPEC_DECIDE) begin
         // start each frame on a whole clock period so no bit goes out unclocked
         div_q <= 2'h0; // see [R14]
      end else begin
         div_q <= (div_q == DIV_LAST) ? 2'h0 : div_q + 2'h1;
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         // same level as the synchroniser's reset, so no false edge follows reset
         link_clk_q <= 1'b1;
      end else begin
         link_clk_q <= link_clk_s;
      end
   end
   assign clk_fall = (div_q == DIV_LAST);
   assign slave_rise = link_clk_s & ~link_clk_q;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_q <= SCPEC_POR;
         por_cnt_q <= 32'h0;
         done_cnt_q <= 5'h0;
         hold_q <= 1'b0;
      end else begin
         unique case (state_q)
            SCPEC_POR: begin
               por_cnt_q <= por_cnt_q + 32'h1;
               if (por_cnt_q >= 32'(POR_COUNT - 1)) begin // see [R1]
                  state_q <= SCPEC_DECIDE;
               end
            end
            SCPEC_DECIDE: begin
               // status line just released; chip select decides the role
               if (!pins.status_low) begin
                  state_q <= pins.sel_high ? SCPEC_SLAVE : SCPEC_SEND; // see [R4]
               end
            end
            SCPEC_SEND: begin
               if (pins.status_low) begin
                  state_q <= SCPEC_RECOVER; // see [R9]
               end else if (pins.sel_high) begin
                  state_q <= SCPEC_ERROR; // see [R6]
               end else if (clk_fall && addr_q == LAST_ADDR) begin
                  state_q <= SCPEC_WAIT_DONE;
                  done_cnt_q <= 5'h0;
               end
            end
            SCPEC_WAIT_DONE: begin
               if (pins.status_low) begin
                  state_q <= SCPEC_RECOVER;
               end else if (pins.sel_high) begin
                  state_q <= SCPEC_IDLE; // see [R12]
               end else if (clk_fall) begin
                  done_cnt_q <= done_cnt_q + 5'h1;
                  if (done_cnt_q == DONE_LAST - 5'h1) begin
                     state_q <= SCPEC_ERROR; // see [R7]
                  end
               end
            end
            SCPEC_IDLE: begin
               if (pins.status_low) begin
                  state_q <= SCPEC_RECOVER;
               end
            end
            SCPEC_SLAVE: begin
               if (pins.status_low) begin
                  state_q <= SCPEC_RECOVER;
               end
            end
            SCPEC_ERROR: begin
               hold_q <= 1'b1;
               // leave only once our own low is back through the synchroniser,
               // else the recover state sees a stale high and restarts at once
               if (hold_q && pins.status_low) begin // see [R15]
                  hold_q <= 1'b0;
                  state_q <= SCPEC_RECOVER;
               end
            end
            SCPEC_RECOVER: begin
               // wait for the line to return high, restart only if allowed
               if (!pins.status_low) begin
                  if (o_error && !i_auto_restart) begin
                     state_q <= SCPEC_IDLE; // see [R8]
                  end else begin
                     state_q <= SCPEC_DECIDE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_error <= 1'b0;
      end else if (state_q == SCPEC_ERROR) begin
         o_error <= 1'b1;
      end else if (state_q == SCPEC_DECIDE) begin
         o_error <= 1'b0;
      end
   end

   // address counter
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || pins.status_low || state_q == SCPEC_DECIDE) begin
         addr_q <= '0; // see [R10]
      end else if (state_q == SCPEC_SEND && !pins.sel_high && clk_fall) begin
         addr_q <= addr_q + 1'b1; // see [R14] see [R11]
      end else if (state_q == SCPEC_SLAVE && !pins.sel_high && slave_rise) begin
         addr_q <= addr_q + 1'b1; // see [R11]
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_status_line_oe_n <= 1'b0;
         o_status_line <= 1'b0;
         o_config_clock <= 1'b0;
         o_config_clock_oe_n <= 1'b0;
         o_data <= 1'b0;
         o_data_oe_n <= 1'b1;
         o_cascade_select_out_n <= 1'b1;
         o_mem_addr <= '0;
         o_slave_mode <= 1'b0;
      end else begin
         o_status_line <= 1'b0;
         // see [R2] see [R3]
         o_status_line_oe_n <= !(state_q == SCPEC_POR || state_q == SCPEC_ERROR);
         // see [R13]
         o_config_clock <= (state_q == SCPEC_SEND || state_q == SCPEC_WAIT_DONE)
                           && (div_q > DIV_HALF);
         o_config_clock_oe_n <= (state_q == SCPEC_SLAVE);
         o_data <= (state_q == SCPEC_IDLE) ? IDLE_DATA_HIGH : i_mem_bit;
         o_data_oe_n <= pins.status_low || pins.sel_high ||
                        !(state_q == SCPEC_SEND || state_q == SCPEC_SLAVE ||
                          state_q == SCPEC_IDLE); // see [R10] see [R11] see [R12]
         o_cascade_select_out_n <= !(state_q == SCPEC_WAIT_DONE);
         o_mem_addr <= addr_q;
         o_slave_mode <= (state_q == SCPEC_SLAVE); // see [R4]
      end
   end

   a_por_drive_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state_q == SCPEC_POR) |=> !o_status_line_oe_n) else $error("status not low in delay"); // see [R2]
   a_por_bound: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (por_cnt_q < 32'(POR_COUNT)) || state_q != SCPEC_POR) else $error("delay too long"); // see [R1]
   a_release_after: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state_q == SCPEC_DECIDE) |=> o_status_line_oe_n) else $error("line not released"); // see [R3]
   // error entry, then the status line pulled low
   sequence s_err_flag;
      (state_q == SCPEC_ERROR) ##1 !o_status_line_oe_n;
   endsequence
   // error state kept for at least two cycles
   sequence s_err_hold;
      (state_q == SCPEC_ERROR) ##1 (state_q == SCPEC_ERROR);
   endsequence

   a_early_done: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state_q == SCPEC_SEND && pins.sel_high && !pins.status_low)
      |=> s_err_flag) else $error("early done missed"); // see [R6]
   a_done_timeout: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state_q == SCPEC_WAIT_DONE) |-> (done_cnt_q < DONE_LAST)) else $error("done wait overrun"); // see [R7]
   a_low_clears: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      pins.status_low |=> (addr_q == '0) && o_data_oe_n) else $error("no clear on low"); // see [R10]
   a_desel_tri: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      pins.sel_high |=> o_data_oe_n) else $error("data driven while deselected"); // see [R11]
   a_slave_tri: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state_q == SCPEC_SLAVE) |=> o_config_clock_oe_n) else $error("slave drives clock"); // see [R4]
   a_error_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(state_q == SCPEC_ERROR) |-> s_err_hold ##[1:4] (state_q == SCPEC_RECOVER))
      else $error("error hold wrong"); // see [R15]
   a_idle_clock: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state_q == SCPEC_IDLE) |=> !o_config_clock) else $error("idle clock high"); // see [R12]
endmodule

/* scpec_target.sv */
// model of the target's configuration port: open-drain status and done lines
// assumes both lines have pull-ups, resolved by the bench
module scpec_target
   import scpec_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_powered,
   input wire logic i_done,
   input wire logic i_crc_err,
   input wire logic i_config_clock,
   input wire logic i_data,
   output logic o_done_line,
   output logic o_status_line,
   output logic [15:0] o_bit_cnt,
   output logic [15:0] o_bits
);
   logic clk_q;
   // a powered target holds done low until it has its data
   assign o_done_line = !(i_powered && !i_done);
   assign o_status_line = !i_crc_err;
   // data is taken at each rising config clock, oldest bit ends up highest
   always_ff @(posedge i_clk_sys) begin
      clk_q <= i_config_clock;
      if (i_rst) begin
         o_bit_cnt <= 16'h0;
         o_bits <= 16'h0;
      end else if (i_config_clock && !clk_q) begin
         o_bit_cnt <= o_bit_cnt + 16'h1;
         o_bits <= {o_bits[14:0], i_data};
      end
   end
endmodule

/* tb.sv */
// testbench for the power-on and error controller
// assumes the target model and pull-ups on status and done lines
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys = 0, i_rst = 1, i_auto_restart = 0, powered = 1;
   logic done_cmd = 0, crc_cmd = 0, ext_clk = 0, ext_en = 0;
   logic o_status_line_oe_n, o_status_line, o_config_clock, o_config_clock_oe_n;
   logic o_data, o_data_oe_n, o_cascade_select_out_n, o_slave_mode, o_error;
   logic done_line, tgt_status;
   logic [15:0] o_mem_addr, bit_cnt, bits;
   wire logic status_w, cfg_w, data_w;
   wire logic [3:0] mon;
   int error_cnt = 0, num_checks = 0;
   assign status_w = (o_status_line_oe_n ? 1'h1 : o_status_line) & tgt_status;
   assign cfg_w = o_config_clock_oe_n ? ext_clk : o_config_clock;
   // an undriven data line shows the inverse, so a missed enable corrupts the stream
   assign data_w = o_data_oe_n ? ~o_data : o_data;
   assign mon = {o_slave_mode, o_cascade_select_out_n, o_status_line_oe_n, o_data_oe_n};
   always #12.5 i_clk_sys = ~i_clk_sys;
   always #100 ext_clk = ext_en ? ~ext_clk : 1'h0;
   scpec_ctrl #(.POR_COUNT(20), .ADDR_W(16), .LAST_ADDR(16'h0008)) scpec_ctrl_i (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_status_line(status_w),
      .i_chip_select_n(done_line), .i_config_clock(cfg_w),
      .i_auto_restart(i_auto_restart), .i_mem_bit(o_mem_addr[0] ^ o_mem_addr[2]),
      .o_status_line_oe_n(o_status_line_oe_n), .o_status_line(o_status_line),
      .o_config_clock(o_config_clock), .o_config_clock_oe_n(o_config_clock_oe_n),
      .o_data(o_data), .o_data_oe_n(o_data_oe_n),
      .o_cascade_select_out_n(o_cascade_select_out_n), .o_mem_addr(o_mem_addr),
      .o_slave_mode(o_slave_mode), .o_error(o_error));
   scpec_target scpec_target_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_powered(powered),
      .i_done(done_cmd), .i_crc_err(crc_cmd), .i_config_clock(cfg_w), .i_data(data_w),
      .o_done_line(done_line), .o_status_line(tgt_status), .o_bit_cnt(bit_cnt),
      .o_bits(bits));
   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   // bit k of mon: 0 data oe_n, 1 status oe_n, 2 cascade_n, 3 slave
   task automatic wait_lvl(input int k, input logic v, input int lim, output int n);
      n = 0;
      while (mon[k] !== v) begin
         if (n == lim) begin
            chk("wait on monitor bit", 16'(k), 16'hFFFF);
            complete_run();
         end
         @(posedge i_clk_sys);
         #1;
         n++;
      end
   endtask
   task automatic do_reset(input logic pw, input logic ar);
      int n;
      @(posedge i_clk_sys);
      i_rst <= 1'h1;
      powered <= pw;
      i_auto_restart <= ar;
      done_cmd <= 1'h0;
      crc_cmd <= 1'h0;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'h0;
      #1;
      chk("status held", 16'h0, o_status_line_oe_n);
      chk("status level", 16'h0, o_status_line);
      wait_lvl(1, 1'h1, 40, n);
      chk("delay length", 16'h1, n >= 18 && n <= 24);
      chk("status released", 16'h1, status_w);
   endtask
   task automatic t_slave;
      int n;
      do_reset(1'h0, 1'h0);
      wait_lvl(3, 1'h1, 10, n);
      ext_en = 1'h1;
      repeat (40) @(posedge i_clk_sys);
      #1;
      chk("slave data oe_n", 16'h1, o_data_oe_n);
      chk("slave clock oe_n", 16'h1, o_config_clock_oe_n);
      chk("slave address", 16'h0, o_mem_addr);
      // target now selects this slave: counter follows the external clock
      @(posedge i_clk_sys);
      powered <= 1'h1;
      repeat (40) @(posedge i_clk_sys);
      #1;
      chk("slave data on", 16'h0, o_data_oe_n);
      chk("slave address run", 16'h1, o_mem_addr >= 16'h3 && o_mem_addr <= 16'h6);
      ext_en = 1'h0;
   endtask
   task automatic t_normal;
      int n;
      do_reset(1'h1, 1'h0);
      wait_lvl(0, 1'h0, 10, n);
      wait_lvl(2, 1'h0, 200, n);
      chk("bits clocked", 16'h9, bit_cnt);
      chk("bit stream", 16'h00B4, bits);
      @(posedge i_clk_sys);
      done_cmd <= 1'h1;
      repeat (12) @(posedge i_clk_sys);
      #1;
      chk("idle clock", 16'h0, o_config_clock);
      chk("idle data", 16'h1, o_data);
      chk("no error", 16'h0, o_error);
   endtask
   task automatic t_missing;
      int n;
      logic [15:0] b;
      do_reset(1'h1, 1'h0);
      wait_lvl(2, 1'h0, 200, n);
      b = bit_cnt;
      wait_lvl(1, 1'h0, 200, n);
      chk("done wait", 16'h1, n >= 62 && n <= 66);
      chk("clock in wait", 16'h1, bit_cnt - b >= 16'hF);
      chk("error set", 16'h1, o_error);
      b = bit_cnt;
      repeat (100) @(posedge i_clk_sys);
      #1;
      chk("no restart", b, bit_cnt);
      chk("status freed", 16'h1, o_status_line_oe_n);
   endtask
   task automatic t_early;
      int n;
      do_reset(1'h1, 1'h1);
      wait_lvl(0, 1'h0, 10, n);
      @(posedge i_clk_sys);
      done_cmd <= 1'h1;
      wait_lvl(1, 1'h0, 20, n);
      chk("error set", 16'h1, o_error);
      @(posedge i_clk_sys);
      done_cmd <= 1'h0;
      wait_lvl(1, 1'h1, 10, n);
      chk("data off", 16'h1, o_data_oe_n);
      wait_lvl(0, 1'h0, 40, n);
      chk("error cleared", 16'h0, o_error);
   endtask
   task automatic t_crc;
      int n;
      do_reset(1'h1, 1'h0);
      wait_lvl(0, 1'h0, 10, n);
      repeat (6) @(posedge i_clk_sys);
      crc_cmd <= 1'h1;
      wait_lvl(0, 1'h1, 6, n);
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk("address cleared", 16'h0, o_mem_addr);
      @(posedge i_clk_sys);
      crc_cmd <= 1'h0;
      wait_lvl(0, 1'h0, 20, n);
   endtask
   initial begin
      t_slave();
      t_normal();
      t_missing();
      t_early();
      t_crc();
      complete_run();
   end
endmodule
